// >>> common/trm_pkg.sv
// Package for the two-timer reload and split-mode block
package trm_pkg;
	localparam logic [2:0] ADDR_CONTROL  = 3'h0;
	localparam logic [2:0] ADDR_MODE     = 3'h1;
	localparam logic [2:0] ADDR_T0_LOW   = 3'h2;
	localparam logic [2:0] ADDR_T0_HIGH  = 3'h3;
	localparam logic [2:0] ADDR_T1_LOW   = 3'h4;
	localparam logic [2:0] ADDR_T1_HIGH  = 3'h5;
	localparam logic [2:0] ADDR_IRQ_STAT = 3'h6;
	localparam logic [2:0] ADDR_IRQ_MASK = 3'h7;
	// Control register bit positions
	localparam int CTL_T0_RUN  = 0;
	localparam int CTL_T1_RUN  = 1;
	localparam int CTL_T0_FLAG = 2;
	localparam int CTL_T1_FLAG = 3;
	// Mode register fields: [1:0] t0 mode, [2] t0 source, [3] t0 gate, [5:4] t1 mode, [6] t1 source, [7] t1 gate
	localparam int MOD_T0_LSB  = 0;
	localparam int MOD_T0_SRC  = 2;
	localparam int MOD_T0_GATE = 3;
	localparam int MOD_T1_LSB  = 4;
	localparam int MOD_T1_SRC  = 6;
	localparam int MOD_T1_GATE = 7;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] ALL_ONES   = 8'hFF;
	typedef enum logic [1:0]
	{
		TRM_MODE_13BIT  = 2'b00,
		TRM_MODE_16BIT  = 2'b01,
		TRM_MODE_RELOAD = 2'b10,
		TRM_MODE_SPLIT  = 2'b11
	} trm_mode_t;
	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} trm_bus_t;
endpackage

// >>> rtl/trm_timers.sv
// Two counter/timers with 13/16-bit, auto-reload and split modes
//Contract
//[RL1] Reload mode: low byte counts, high byte holds the reload value.
//[RL2] Low byte rolling FF to 00 sets overflow flag and reloads from high byte.
//[RL3] Overflow flag set with interrupt enabled raises the interrupt request.
//[RL4] Reload never alters the high-byte reload value.
//[RL5] Software preloads the low byte before starting the timer.
//[RL6] Second timer in reload mode behaves like the first with its own bytes.
//[RL7] Split mode makes the first timer two independent 8-bit counters.
//[RL8] Split low counter uses first timer run, source, gate bits and flag.
//[RL9] Split low counter counts system clock or external input by source select.
//[RL10] Split high counter counts only the system clock.
//[RL11] Split high counter runs only while second timer run bit is set.
//[RL12] Split high counter overflow sets second timer flag and its interrupt.
//[RL13] Second timer in split mode stops and holds; leaving it resumes.
//[RL14] With first timer split, second timer ignores external input, never sets flag.
//[RL15] Second timer overflow pulses still feed serial baud clocks.
//[RL16] With gate set, counting needs run bit and gate input high.
//[RL17] Flags stay set until software clears; reset zeros counters and controls.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module trm_timers
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       clk_en_i,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       t0_count_pin_i,
	input  wire logic       t1_count_pin_i,
	input  wire logic       t0_gate_pin_i,
	input  wire logic       t1_gate_pin_i,
	output logic            baud_tick_o,
	output logic            irq_o
);
	logic                 rst_meta;
	logic                 rst_sync_n;
	logic [3:0]           pin_meta;
	logic [3:0]           pin_sync;
	logic                 t0_cnt_prev;
	logic                 t1_cnt_prev;
	logic [7:0]           timer_control_reg;
	logic [7:0]           timer_mode_reg;
	logic [7:0]           timer0_low_count;
	logic [7:0]           timer0_high_reload;
	logic [7:0]           t1_low;
	logic [7:0]           t1_high;
	logic [1:0]           irq_stat;
	logic [1:0]           irq_mask;
	trm_pkg::trm_bus_t    bus;
	trm_pkg::trm_mode_t   t0_mode;
	trm_pkg::trm_mode_t   t1_mode;
	logic                 timer0_run_bit;
	logic                 timer1_run_bit;
	logic                 timer0_count_source_select;
	logic                 timer0_gate_enable;
	logic                 t1_src;
	logic                 t1_gate;
	logic                 t0_split;
	logic                 t0_tick;
	logic                 t1_tick;
	logic                 th_tick;
	logic                 t0_ovf;
	logic                 t1_ovf;
	logic                 th_ovf;
	logic                 next_t0_flag;
	logic                 next_t1_flag;
	logic                 t0_ext_edge;
	logic                 t1_ext_edge;

	assign bus.wr    = wr_i;
	assign bus.rd    = rd_i;
	assign bus.addr  = addr_i;
	assign bus.wdata = wdata_i;

	// Reset release through two flops
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Pin synchronisers; the external count edge is taken from the second stage only
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pin_meta    <= 4'h0;
			pin_sync    <= 4'h0;
			t0_cnt_prev <= 1'b0;
			t1_cnt_prev <= 1'b0;
		end
		else if (clk_en_i)
		begin
			pin_meta    <= {t1_gate_pin_i, t0_gate_pin_i, t1_count_pin_i, t0_count_pin_i};
			pin_sync    <= pin_meta;
			t0_cnt_prev <= pin_sync[0];
			t1_cnt_prev <= pin_sync[1];
		end
	end

	// External input counts on falling edges
	assign t0_ext_edge = t0_cnt_prev & ~pin_sync[0];
	assign t1_ext_edge = t1_cnt_prev & ~pin_sync[1];

	assign timer0_run_bit             = timer_control_reg[trm_pkg::CTL_T0_RUN];
	assign timer1_run_bit             = timer_control_reg[trm_pkg::CTL_T1_RUN];
	assign t0_mode                    = trm_pkg::trm_mode_t'(timer_mode_reg[trm_pkg::MOD_T0_LSB +: 2]);
	assign t1_mode                    = trm_pkg::trm_mode_t'(timer_mode_reg[trm_pkg::MOD_T1_LSB +: 2]);
	assign timer0_count_source_select = timer_mode_reg[trm_pkg::MOD_T0_SRC];
	assign timer0_gate_enable         = timer_mode_reg[trm_pkg::MOD_T0_GATE];
	assign t1_src                     = timer_mode_reg[trm_pkg::MOD_T1_SRC];
	assign t1_gate                    = timer_mode_reg[trm_pkg::MOD_T1_GATE];
	assign t0_split                   = (t0_mode == trm_pkg::TRM_MODE_SPLIT);

	// Timer 0 low counter tick, in every mode
	always_comb
	begin
		t0_tick = timer0_run_bit & (~timer0_gate_enable | pin_sync[2]); // [RL8] [RL16]
		if (timer0_count_source_select)
			t0_tick = t0_tick & t0_ext_edge; // [RL9]
	end

	// Split-mode high counter: system clock only, run by timer 1 run bit
	assign th_tick = t0_split & timer1_run_bit; // [RL10] [RL11]

	// Timer 1 tick; gate and source are moot once timer 0 borrows its run bit
	always_comb
	begin
		t1_tick = 1'b0;
		if (t1_mode != trm_pkg::TRM_MODE_SPLIT) // [RL13]
		begin
			if (t0_split)
				t1_tick = 1'b1; // [RL14]
			else
			begin
				t1_tick = timer1_run_bit & (~t1_gate | pin_sync[3]);
				if (t1_src)
					t1_tick = t1_tick & t1_ext_edge;
			end
		end
	end

	// Overflow detection per mode
	always_comb
	begin
		case (t0_mode)
			trm_pkg::TRM_MODE_13BIT:  t0_ovf = t0_tick & (timer0_low_count[4:0] == 5'h1F)
				& (timer0_high_reload == trm_pkg::ALL_ONES);
			trm_pkg::TRM_MODE_16BIT:  t0_ovf = t0_tick & (timer0_low_count == trm_pkg::ALL_ONES)
				& (timer0_high_reload == trm_pkg::ALL_ONES);
			default:                  t0_ovf = t0_tick & (timer0_low_count == trm_pkg::ALL_ONES); // [RL2] [RL7]
		endcase
		case (t1_mode)
			trm_pkg::TRM_MODE_13BIT:  t1_ovf = t1_tick & (t1_low[4:0] == 5'h1F) & (t1_high == trm_pkg::ALL_ONES);
			trm_pkg::TRM_MODE_16BIT:  t1_ovf = t1_tick & (t1_low == trm_pkg::ALL_ONES) & (t1_high == trm_pkg::ALL_ONES);
			trm_pkg::TRM_MODE_RELOAD: t1_ovf = t1_tick & (t1_low == trm_pkg::ALL_ONES); // [RL6]
			default:                  t1_ovf = 1'b0;
		endcase
		th_ovf = th_tick & (timer0_high_reload == trm_pkg::ALL_ONES);
	end

	// Timer 0 counting; software writes take precedence over a tick
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			timer0_low_count   <= trm_pkg::RESET_BYTE; // [RL17]
			timer0_high_reload <= trm_pkg::RESET_BYTE;
		end
		else if (clk_en_i)
		begin
			case (t0_mode)
				trm_pkg::TRM_MODE_13BIT:
				begin
					if (t0_tick)
					begin
						timer0_low_count[4:0] <= timer0_low_count[4:0] + 5'h01;
						if (timer0_low_count[4:0] == 5'h1F)
							timer0_high_reload <= timer0_high_reload + 8'h01;
					end
				end
				trm_pkg::TRM_MODE_16BIT:
				begin
					if (t0_tick)
					begin
						timer0_low_count <= timer0_low_count + 8'h01;
						if (timer0_low_count == trm_pkg::ALL_ONES)
							timer0_high_reload <= timer0_high_reload + 8'h01;
					end
				end
				trm_pkg::TRM_MODE_RELOAD:
				begin
					if (t0_ovf)
						timer0_low_count <= timer0_high_reload; // [RL1] [RL2] [RL4]
					else if (t0_tick)
						timer0_low_count <= timer0_low_count + 8'h01;
				end
				trm_pkg::TRM_MODE_SPLIT:
				begin
					if (t0_tick)
						timer0_low_count <= timer0_low_count + 8'h01; // [RL7]
					if (th_tick)
						timer0_high_reload <= timer0_high_reload + 8'h01; // [RL7] [RL10]
				end
				default:
				begin
				end
			endcase
			if (bus.wr && bus.addr == trm_pkg::ADDR_T0_LOW)
				timer0_low_count <= bus.wdata; // [RL5]
			if (bus.wr && bus.addr == trm_pkg::ADDR_T0_HIGH)
				timer0_high_reload <= bus.wdata;
		end
	end

	// Timer 1 counting; holds its value while its own mode is split
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			t1_low  <= trm_pkg::RESET_BYTE;
			t1_high <= trm_pkg::RESET_BYTE;
		end
		else if (clk_en_i)
		begin
			case (t1_mode)
				trm_pkg::TRM_MODE_13BIT:
				begin
					if (t1_tick)
					begin
						t1_low[4:0] <= t1_low[4:0] + 5'h01;
						if (t1_low[4:0] == 5'h1F)
							t1_high <= t1_high + 8'h01;
					end
				end
				trm_pkg::TRM_MODE_16BIT:
				begin
					if (t1_tick)
					begin
						t1_low <= t1_low + 8'h01;
						if (t1_low == trm_pkg::ALL_ONES)
							t1_high <= t1_high + 8'h01;
					end
				end
				trm_pkg::TRM_MODE_RELOAD:
				begin
					if (t1_ovf)
						t1_low <= t1_high; // [RL6] [RL4]
					else if (t1_tick)
						t1_low <= t1_low + 8'h01;
				end
				default:
				begin
				end
			endcase
			if (bus.wr && bus.addr == trm_pkg::ADDR_T1_LOW)
				t1_low <= bus.wdata;
			if (bus.wr && bus.addr == trm_pkg::ADDR_T1_HIGH)
				t1_high <= bus.wdata;
		end
	end

	// Flags: a set in the same cycle as a software clear wins
	always_comb
	begin
		next_t0_flag = timer_control_reg[trm_pkg::CTL_T0_FLAG];
		next_t1_flag = timer_control_reg[trm_pkg::CTL_T1_FLAG];
		if (bus.wr && bus.addr == trm_pkg::ADDR_CONTROL)
		begin
			next_t0_flag = bus.wdata[trm_pkg::CTL_T0_FLAG];
			next_t1_flag = bus.wdata[trm_pkg::CTL_T1_FLAG];
		end
		if (t0_ovf)
			next_t0_flag = 1'b1; // [RL2] [RL8] [RL17]
		if (th_ovf || (t1_ovf && !t0_split))
			next_t1_flag = 1'b1; // [RL12] [RL14]
	end

	// Control and mode registers
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			timer_control_reg <= trm_pkg::RESET_BYTE; // [RL17]
			timer_mode_reg    <= trm_pkg::RESET_BYTE;
			irq_mask          <= 2'h0;
		end
		else if (clk_en_i)
		begin
			if (bus.wr && bus.addr == trm_pkg::ADDR_CONTROL)
				timer_control_reg[1:0] <= bus.wdata[1:0];
			timer_control_reg[trm_pkg::CTL_T0_FLAG] <= next_t0_flag;
			timer_control_reg[trm_pkg::CTL_T1_FLAG] <= next_t1_flag;
			if (bus.wr && bus.addr == trm_pkg::ADDR_MODE)
				timer_mode_reg <= bus.wdata;
			if (bus.wr && bus.addr == trm_pkg::ADDR_IRQ_MASK)
				irq_mask <= bus.wdata[1:0];
		end
	end

	// Sticky interrupt status, cleared by reading it; a new event in the read cycle survives
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			irq_stat <= 2'h0;
		else if (clk_en_i)
		begin
			if (bus.rd && bus.addr == trm_pkg::ADDR_IRQ_STAT)
				irq_stat <= {next_t1_flag & ~timer_control_reg[trm_pkg::CTL_T1_FLAG],
					next_t0_flag & ~timer_control_reg[trm_pkg::CTL_T0_FLAG]};
			else
				irq_stat <= irq_stat | {next_t1_flag & ~timer_control_reg[trm_pkg::CTL_T1_FLAG],
					next_t0_flag & ~timer_control_reg[trm_pkg::CTL_T0_FLAG]}; // [RL3] [RL12]
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			irq_o       <= 1'b0;
			baud_tick_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			irq_o       <= |(irq_stat & irq_mask); // [RL3]
			baud_tick_o <= t1_ovf; // [RL15]
		end
	end

	// Read port: data in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			rdata_o <= trm_pkg::RESET_BYTE;
		else if (clk_en_i)
		begin
			rdata_o <= trm_pkg::RESET_BYTE;
			if (bus.rd)
			begin
				case (bus.addr)
					trm_pkg::ADDR_CONTROL:  rdata_o <= timer_control_reg;
					trm_pkg::ADDR_MODE:     rdata_o <= timer_mode_reg;
					trm_pkg::ADDR_T0_LOW:   rdata_o <= timer0_low_count;
					trm_pkg::ADDR_T0_HIGH:  rdata_o <= timer0_high_reload;
					trm_pkg::ADDR_T1_LOW:   rdata_o <= t1_low;
					trm_pkg::ADDR_T1_HIGH:  rdata_o <= t1_high;
					trm_pkg::ADDR_IRQ_STAT: rdata_o <= {6'h00, irq_stat};
					trm_pkg::ADDR_IRQ_MASK: rdata_o <= {6'h00, irq_mask};
					default:                rdata_o <= trm_pkg::RESET_BYTE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb_trm_timers.sv
// Self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
module tb_trm_timers;
	logic        clk_i;
	logic        reset_n_i;
	logic [2:0]  addr_i;
	logic [7:0]  wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [7:0]  rdata_o;
	logic        t0_count_pin;
	logic        t0_gate_pin;
	logic        baud_tick_o;
	logic        irq_o;
	logic [15:0] ticks;
	logic        seen;
	logic [7:0]  v;
	logic [15:0] t;
	int          n_fail;
	int          check_count;
	int          cyc;
	trm_timers u_trm_timers (.clk_i, .reset_n_i, .clk_en_i(1'b1), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.t0_count_pin_i(t0_count_pin), .t1_count_pin_i(1'b0), .t0_gate_pin_i(t0_gate_pin),
		.t1_gate_pin_i(1'b0), .baud_tick_o, .irq_o);
	trm_far_end u_trm_far_end (.clk_i, .reset_n_i, .baud_tick_i(baud_tick_o), .irq_i(irq_o),
		.tick_count_o(ticks), .irq_seen_o(seen));
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkr(input logic [2:0] a, input logic [7:0] exp);
		rd(a, v);
		chk(v, exp);
	endtask
	// Pin pulses are long enough to survive the input synchroniser
	task automatic pulse3;
		repeat (3)
		begin
			t0_count_pin <= 1'b1;
			idle(4);
			t0_count_pin <= 1'b0;
			idle(6);
		end
	endtask
	task automatic wrap_up;
		$display("checks=%0d failures=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			n_fail++;
			wrap_up();
		end
	end
	initial
	begin
		reset_n_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 3'h0;
		wdata_i = 8'h00;
		t0_count_pin = 1'b0;
		t0_gate_pin = 1'b0;
		n_fail = 0;
		check_count = 0;
		idle(10);
		reset_n_i <= 1'b1;
		idle(4);
		chkr(trm_pkg::ADDR_CONTROL, 8'h00);
		chkr(trm_pkg::ADDR_T0_LOW, 8'h00);
		$display("test reset done");
		wr(trm_pkg::ADDR_MODE, 8'h02);
		wr(trm_pkg::ADDR_T0_HIGH, 8'hFC);
		wr(trm_pkg::ADDR_T0_LOW, 8'hFC);
		wr(trm_pkg::ADDR_IRQ_MASK, 8'h01);
		wr(trm_pkg::ADDR_CONTROL, 8'h01);
		idle(20);
		chkr(trm_pkg::ADDR_CONTROL, 8'h05);
		chk({7'h0, irq_o}, 8'h01);
		chkr(trm_pkg::ADDR_T0_HIGH, 8'hFC);
		wr(trm_pkg::ADDR_CONTROL, 8'h04);
		idle(4);
		chkr(trm_pkg::ADDR_CONTROL, 8'h04);
		rd(trm_pkg::ADDR_T0_LOW, v);
		chk({7'h0, v >= 8'hFC}, 8'h01);
		wr(trm_pkg::ADDR_CONTROL, 8'h00);
		chkr(trm_pkg::ADDR_IRQ_STAT, 8'h01);
		chkr(trm_pkg::ADDR_IRQ_STAT, 8'h00);
		idle(2);
		chk({7'h0, irq_o}, 8'h00);
		chk({7'h0, seen}, 8'h01);
		$display("test timer0 reload done");
		wr(trm_pkg::ADDR_MODE, 8'h20);
		wr(trm_pkg::ADDR_T1_HIGH, 8'hF0);
		wr(trm_pkg::ADDR_T1_LOW, 8'hF0);
		t = ticks;
		wr(trm_pkg::ADDR_CONTROL, 8'h02);
		idle(100);
		chkr(trm_pkg::ADDR_CONTROL, 8'h0A);
		chkr(trm_pkg::ADDR_T1_HIGH, 8'hF0);
		chk({7'h0, ticks - t >= 16'h0005}, 8'h01);
		wr(trm_pkg::ADDR_CONTROL, 8'h00);
		$display("test timer1 reload done");
		// Second timer set to external source and gate, which split mode must ignore
		wr(trm_pkg::ADDR_MODE, 8'hE3);
		wr(trm_pkg::ADDR_T0_LOW, 8'h00);
		wr(trm_pkg::ADDR_T0_HIGH, 8'hF8);
		t = ticks;
		idle(40);
		chkr(trm_pkg::ADDR_T0_HIGH, 8'hF8);
		chkr(trm_pkg::ADDR_T0_LOW, 8'h00);
		chkr(trm_pkg::ADDR_CONTROL, 8'h00);
		chk({7'h0, ticks != t}, 8'h01);
		wr(trm_pkg::ADDR_CONTROL, 8'h03);
		idle(20);
		chkr(trm_pkg::ADDR_CONTROL, 8'h0B);
		rd(trm_pkg::ADDR_T0_LOW, v);
		chk({7'h0, v != 8'h00}, 8'h01);
		chkr(trm_pkg::ADDR_IRQ_STAT, 8'h02);
		wr(trm_pkg::ADDR_CONTROL, 8'h00);
		$display("test split done");
		wr(trm_pkg::ADDR_MODE, 8'h33);
		idle(3);
		t = ticks;
		rd(trm_pkg::ADDR_T1_LOW, v);
		idle(30);
		chkr(trm_pkg::ADDR_T1_LOW, v);
		chk({7'h0, ticks == t}, 8'h01);
		wr(trm_pkg::ADDR_MODE, 8'h23);
		idle(40);
		chk({7'h0, ticks != t}, 8'h01);
		$display("test park done");
		wr(trm_pkg::ADDR_MODE, 8'h0F);
		wr(trm_pkg::ADDR_T0_LOW, 8'h10);
		wr(trm_pkg::ADDR_CONTROL, 8'h01);
		pulse3();
		idle(6);
		chkr(trm_pkg::ADDR_T0_LOW, 8'h10);
		t0_gate_pin <= 1'b1;
		pulse3();
		idle(6);
		chkr(trm_pkg::ADDR_T0_LOW, 8'h13);
		wr(trm_pkg::ADDR_CONTROL, 8'h00);
		$display("test gate and pin done");
		wr(trm_pkg::ADDR_IRQ_MASK, 8'h00);
		wr(trm_pkg::ADDR_MODE, 8'h02);
		wr(trm_pkg::ADDR_T0_HIGH, 8'hFC);
		wr(trm_pkg::ADDR_T0_LOW, 8'hFC);
		wr(trm_pkg::ADDR_CONTROL, 8'h01);
		idle(20);
		chk({7'h0, irq_o}, 8'h00);
		chkr(trm_pkg::ADDR_IRQ_STAT, 8'h01);
		reset_n_i <= 1'b0;
		idle(3);
		reset_n_i <= 1'b1;
		idle(4);
		chkr(trm_pkg::ADDR_CONTROL, 8'h00);
		$display("test mask and reset done");
		wrap_up();
	end
endmodule
`default_nettype wire

// >>> tb/trm_far_end.sv
// Serial-side consumer of baud ticks and the interrupt level
`timescale 1ns/1ps
`default_nettype none
module trm_far_end
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        baud_tick_i,
	input  wire logic        irq_i,
	output logic      [15:0] tick_count_o,
	output logic             irq_seen_o
);
	// A serial shift divider only counts ticks, so a count is all it needs
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tick_count_o <= 16'h0000;
			irq_seen_o   <= 1'b0;
		end
		else
		begin
			tick_count_o <= tick_count_o + {15'h0, baud_tick_i};
			irq_seen_o   <= irq_seen_o | irq_i;
		end
	end
endmodule
`default_nettype wire

// >>> tb/trm_timers_sva.sv
// Port checker for the timer block
`timescale 1ns/1ps
`default_nettype none
module trm_timers_sva
(
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       clk_en_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       t0_count_pin_i,
	input wire logic       t1_count_pin_i,
	input wire logic       t0_gate_pin_i,
	input wire logic       t1_gate_pin_i,
	input wire logic       baud_tick_o,
	input wire logic       irq_o
);
	logic [7:0] mode_sh;
	logic [7:0] hi0;
	logic [1:0] run_sh;
	logic [1:0] mask_sh;
	logic       hi0_ok;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Shadows of software writes; the reload byte is trusted only if written in reload mode
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mode_sh <= 8'h00;
			hi0     <= 8'h00;
			run_sh  <= 2'h0;
			mask_sh <= 2'h0;
			hi0_ok  <= 1'b0;
		end
		else if (wr_i && clk_en_i)
		begin
			if (addr_i == trm_pkg::ADDR_MODE)
				mode_sh <= wdata_i;
			if (addr_i == trm_pkg::ADDR_MODE)
				hi0_ok <= 1'b0;
			if (addr_i == trm_pkg::ADDR_T0_HIGH)
				hi0 <= wdata_i;
			if (addr_i == trm_pkg::ADDR_T0_HIGH)
				hi0_ok <= (mode_sh[1:0] == 2'h2);
			if (addr_i == trm_pkg::ADDR_CONTROL)
				run_sh <= wdata_i[1:0];
			if (addr_i == trm_pkg::ADDR_IRQ_MASK)
				mask_sh <= wdata_i[1:0];
		end
	end
	a_reset_quiet: assert property (disable iff (1'b0) (!reset_n_i) [*2] |-> !irq_o && !baud_tick_o)
		else $error("outputs active in reset");
	a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read slot");
	a_run_readback: assert property (rd_i && addr_i == trm_pkg::ADDR_CONTROL |=> rdata_o[1:0] == $past(run_sh))
		else $error("run bits lost");
	a_mode_readback: assert property (rd_i && addr_i == trm_pkg::ADDR_MODE |=> rdata_o == $past(mode_sh))
		else $error("mode byte lost");
	a_reload_kept: assert property (rd_i && addr_i == trm_pkg::ADDR_T0_HIGH && hi0_ok |=> rdata_o == $past(hi0))
		else $error("reload byte altered");
	a_irq_masked: assert property (irq_o |-> mask_sh != 2'h0 || $past(mask_sh) != 2'h0)
		else $error("interrupt without mask");
	a_split_hold: assert property (mode_sh[5:4] == 2'h3 [*3] |-> !baud_tick_o)
		else $error("tick while second timer parked");
	a_tick_needs_run: assert property (baud_tick_o |-> run_sh[1] || $past(run_sh[1]) || $past(run_sh[1], 2)
		|| mode_sh[1:0] == 2'h3 || $past(mode_sh[1:0]) == 2'h3)
		else $error("tick from stopped timer");
	c_irq: cover property ($rose(irq_o));
	c_tick: cover property (baud_tick_o);
	c_reload_read: cover property (rd_i && addr_i == trm_pkg::ADDR_T0_HIGH && hi0_ok);
endmodule
bind trm_timers trm_timers_sva u_trm_timers_sva (.clk_i, .reset_n_i, .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .t0_count_pin_i, .t1_count_pin_i, .t0_gate_pin_i, .t1_gate_pin_i, .baud_tick_o, .irq_o);
`default_nettype wire
